// File: verilog/psw_cfg.svh
// offsets, field positions and reset values of the status word
`ifndef PSW_CFG_SVH
`define PSW_CFG_SVH
`define SFR_ADDR_STATUS 8'hd0
`define STATUS_RESET 8'h00
`define BIT_CARRY 7
`define BIT_HALF 6
`define BIT_USER_A 5
`define BIT_BANK_HI 4
`define BIT_BANK_LO 3
`define BIT_OVERFLOW 2
`define BIT_USER_B 1
`define BIT_PARITY 0
`define BANK_SIZE_LOG2 3
`endif

// File: verilog/psw_pkg.sv
// types shared by the status word logic
package psw_pkg;
  typedef enum logic [5:0] {
    OP_NONE = 6'h01,
    OP_ADD = 6'h02,
    OP_ADD_WITH_CARRY_OP = 6'h04,
    OP_SUBTRACT_WITH_BORROW_OP = 6'h08,
    OP_MUL = 6'h10,
    OP_DIV = 6'h20
  } arith_op_t;
endpackage : psw_pkg

// File: verilog/program_status_flags.sv
// program status word: arithmetic flags, user flags, bank select, parity
`timescale 1ns/1ps
`include "psw_cfg.svh"
module program_status_flags
  import psw_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic bit_wr,
  input wire logic [2:0] bit_sel,
  input wire logic bit_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire arith_op_t op,
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  input wire logic [7:0] mul_hi,
  input wire logic [7:0] acc,
  input wire logic [2:0] reg_index,
  output logic [4:0] reg_addr,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic overflow_flag,
  output logic [1:0] bank_select,
  output logic user_flag_a,
  output logic user_flag_b
);

  // refuse widths the flag logic cannot serve
  if (DATA_W != 8) begin : g_width_check
    $error("program_status_flags serves only 8-bit data");
  end

  // ----------------------------------------
  // arithmetic results
  // ----------------------------------------
  logic carry_in;
  logic is_sub;
  logic [8:0] full_sum;
  logic [4:0] nib_sum;
  logic [7:0] b_eff;
  logic signed_ovf;
  logic is_addsub;
  logic [7:0] next_word;
  logic parity;
  logic [7:0] status_view;
  logic status_sel;

  assign is_sub = (op == OP_SUBTRACT_WITH_BORROW_OP);
  assign is_addsub = (op == OP_ADD) || (op == OP_ADD_WITH_CARRY_OP) || (op == OP_SUBTRACT_WITH_BORROW_OP);
  assign carry_in = (op == OP_ADD) ? 1'b0 : carry_flag;
  assign b_eff = is_sub ? ~op_b : op_b;
  // subtract as a + ~b + ~borrow; carry out inverted gives borrow
  assign full_sum = {1'b0, op_a} + {1'b0, b_eff} + {8'h00, is_sub ^ carry_in};
  assign nib_sum = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, is_sub ^ carry_in};
  assign signed_ovf = (op_a[7] == b_eff[7]) && (full_sum[7] != op_a[7]);

  assign parity = ^acc;

  // ----------------------------------------
  // status word access
  // ----------------------------------------
  // address decode
  assign status_sel = (sfr_addr == `SFR_ADDR_STATUS);

  always_comb begin
    status_view = 8'h00;
    status_view[`BIT_CARRY] = carry_flag;
    status_view[`BIT_HALF] = half_carry_flag;
    status_view[`BIT_USER_A] = user_flag_a;
    status_view[`BIT_BANK_HI:`BIT_BANK_LO] = bank_select;
    status_view[`BIT_OVERFLOW] = overflow_flag;
    status_view[`BIT_USER_B] = user_flag_b;
    status_view[`BIT_PARITY] = parity;
  end

  always_comb begin
    next_word = status_view;
    if (status_sel && sfr_wr) begin
      next_word = sfr_wdata;
    end else if (status_sel && bit_wr) begin
      next_word[bit_sel] = bit_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      user_flag_a <= 1'b0;
      user_flag_b <= 1'b0;
      bank_select <= 2'h0;
    end else begin
      user_flag_a <= next_word[`BIT_USER_A];
      user_flag_b <= next_word[`BIT_USER_B];
      bank_select <= next_word[`BIT_BANK_HI:`BIT_BANK_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      carry_flag <= 1'b0;
      half_carry_flag <= 1'b0;
    end else if (is_addsub) begin
      carry_flag <= full_sum[8] ^ is_sub;
      half_carry_flag <= nib_sum[4] ^ is_sub;
    end else if (op == OP_MUL || op == OP_DIV) begin
      carry_flag <= 1'b0;
      half_carry_flag <= 1'b0;
    end else begin
      carry_flag <= next_word[`BIT_CARRY];
      half_carry_flag <= next_word[`BIT_HALF];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_flag <= 1'b0;
    end else if (is_addsub) begin
      overflow_flag <= signed_ovf;
    end else if (op == OP_MUL) begin
      overflow_flag <= (mul_hi != 8'h00);
    end else if (op == OP_DIV) begin
      overflow_flag <= (op_b == 8'h00);
    end else begin
      overflow_flag <= next_word[`BIT_OVERFLOW];
    end
  end

  // registered read port, parity not writable
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= `STATUS_RESET;
      sfr_hit <= 1'b0;
    end else begin
      sfr_hit <= status_sel && sfr_rd;
      sfr_rdata <= (status_sel && sfr_rd) ? status_view : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_addr <= 5'h00;
    end else begin
      reg_addr <= {next_word[`BIT_BANK_HI:`BIT_BANK_LO], reg_index};
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_mul_overflow: assert property (@(posedge clk) disable iff (rst)
    (op == OP_MUL) |=> (overflow_flag == ($past(mul_hi) != 8'h00)))
    else $error("multiply overflow wrong");
  a_div_zero: assert property (@(posedge clk) disable iff (rst)
    (op == OP_DIV && op_b == 8'h00) |=> overflow_flag)
    else $error("divide by zero not flagged");
  a_div_clear: assert property (@(posedge clk) disable iff (rst)
    (op == OP_DIV && op_b != 8'h00) |=> !overflow_flag)
    else $error("divide overflow not cleared");
  a_add_carry: assert property (@(posedge clk) disable iff (rst)
    (op == OP_ADD) |=> (carry_flag == ($past({1'b0, op_a}) + $past({1'b0, op_b}) > 9'h0ff)))
    else $error("add carry wrong");
  a_muldiv_clear: assert property (@(posedge clk) disable iff (rst)
    (op == OP_MUL || op == OP_DIV) |=> !carry_flag && !half_carry_flag)
    else $error("multiply or divide left carry flags set");
  a_subtract_with_borrow_op_borrow: assert property (@(posedge clk) disable iff (rst)
    (op == OP_SUBTRACT_WITH_BORROW_OP && op_b == 8'h00 && !carry_flag) |=> !carry_flag)
    else $error("borrow raised without cause");
  a_half_carry: assert property (@(posedge clk) disable iff (rst)
    (op == OP_ADD) |=> (half_carry_flag == ($past({1'b0, op_a[3:0]}) + $past({1'b0, op_b[3:0]})
      > 5'h0f)))
    else $error("half carry wrong");
  a_add_ovf: assert property (@(posedge clk) disable iff (rst)
    (op == OP_ADD && op_a == 8'h7f && op_b == 8'h01) |=> overflow_flag)
    else $error("signed overflow missed");
  a_user_stable: assert property (@(posedge clk) disable iff (rst)
    !(status_sel && (sfr_wr || bit_wr)) |=> $stable(user_flag_a) && $stable(user_flag_b))
    else $error("user flag changed without write");
  a_bank_map: assert property (@(posedge clk) disable iff (rst)
    ##1 !$past(status_sel && (sfr_wr || bit_wr)) |-> reg_addr == {bank_select, $past(reg_index)})
    else $error("bank mapping wrong");
  a_parity_read: assert property (@(posedge clk) disable iff (rst)
    (status_sel && sfr_rd) |=> sfr_rdata[`BIT_PARITY] == ^$past(acc))
    else $error("parity read wrong");

endmodule : program_status_flags

// File: bench/core_model.sv
// execution datapath model that presents one instruction per request
`timescale 1ns/1ps
module core_model
  import psw_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire arith_op_t req_op,
  input wire logic [7:0] req_a,
  input wire logic [7:0] req_b,
  input wire logic [7:0] req_hi,
  output arith_op_t op,
  output logic [7:0] op_a,
  output logic [7:0] op_b,
  output logic [7:0] mul_hi
);
  // idle operands toggle so stale values never look valid
  always_ff @(posedge clk) begin
    op <= go ? req_op : OP_NONE;
    op_a <= go ? req_a : ~op_a;
    op_b <= go ? req_b : ~op_b;
    mul_hi <= go ? req_hi : ~mul_hi;
  end
endmodule : core_model

// File: bench/program_status_flags_tb.sv
// self-checking bench for the status word logic
`timescale 1ns/1ps
module program_status_flags_tb
  import psw_pkg::*;
;
  logic clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, bit_wr = 0, bit_wdata = 0, go = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, req_a = 0, req_b = 0, req_hi = 0, acc = 0;
  logic [2:0] bit_sel = 0, reg_index = 0;
  arith_op_t req_op = OP_NONE, op;
  logic [7:0] op_a, op_b, mul_hi, sfr_rdata, w, d, a, b, hi;
  logic [4:0] reg_addr;
  logic [1:0] bank_select;
  logic carry_flag, half_carry_flag, overflow_flag, user_flag_a, user_flag_b, sfr_hit;
  int n_fail = 0, checks_done = 0;
  arith_op_t ops [5] = '{OP_ADD, OP_ADD_WITH_CARRY_OP, OP_SUBTRACT_WITH_BORROW_OP, OP_MUL, OP_DIV};
  always #5 clk = ~clk;
  core_model partner (.clk, .go, .req_op, .req_a, .req_b, .req_hi, .op, .op_a, .op_b, .mul_hi);
  program_status_flags uut (.clk, .rst, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .bit_wr,
    .bit_sel, .bit_wdata, .sfr_rdata, .sfr_hit, .op, .op_a, .op_b, .mul_hi, .acc, .reg_index,
    .reg_addr, .carry_flag, .half_carry_flag, .overflow_flag, .bank_select, .user_flag_a,
    .user_flag_b);
  // ----------------------------------------
  // expectations and bus cycles
  // ----------------------------------------
  // flag model
  function automatic logic [2:0] flags(arith_op_t o, logic [7:0] a, b, hi, logic ci);
    logic [8:0] s;
    logic [4:0] n;
    logic sub;
    sub = (o == OP_SUBTRACT_WITH_BORROW_OP);
    ci = (o == OP_ADD) ? 1'b0 : ci;
    s = sub ? {1'b0, a} - b - ci : {1'b0, a} + b + ci;
    n = sub ? {1'b0, a[3:0]} - b[3:0] - ci : {1'b0, a[3:0]} + b[3:0] + ci;
    if (o == OP_MUL) return {1'b0, 1'b0, hi != 8'h00};
    if (o == OP_DIV) return {1'b0, 1'b0, b == 8'h00};
    return {s[8], n[4], (a[7] ^ s[7]) & (sub ? a[7] ^ b[7] : ~(a[7] ^ b[7]))};
  endfunction : flags
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic sfr(logic wr, rd, bw, logic [7:0] ad, dt, logic [2:0] bs, logic bv);
    @(posedge clk);
    sfr_wr <= wr;
    sfr_rd <= rd;
    bit_wr <= bw;
    sfr_addr <= ad;
    sfr_wdata <= dt;
    bit_sel <= bs;
    bit_wdata <= bv;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    bit_wr <= 1'b0;
    #1;
  endtask : sfr
  task automatic arith(arith_op_t o, logic [7:0] a, b, hi);
    @(posedge clk);
    go <= 1'b1;
    req_op <= o;
    req_a <= a;
    req_b <= b;
    req_hi <= hi;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
  endtask : arith
  task automatic corner(arith_op_t o, logic [7:0] a, b, hi);
    logic [2:0] seen;
    {w[7], w[6], w[2]} = flags(o, a, b, hi, w[7]);
    arith(o, a, b, hi);
    seen = {carry_flag, half_carry_flag, overflow_flag};
    chk("corner", {5'h0, w[7:6], w[2]}, {5'h0, seen});
  endtask : corner
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(73));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    w = 8'h00;
    sfr(0, 1, 0, 8'hd0, 0, 0, 0);
    chk("reset word", 8'h00, sfr_rdata);
    chk("hit", 8'h01, {7'h0, sfr_hit});
    sfr(0, 1, 0, 8'h50, 0, 0, 0);
    chk("other read", 8'h00, sfr_rdata);
    chk("other hit", 8'h00, {7'h0, sfr_hit});
    corner(OP_ADD, 8'h7f, 8'h01, 8'h00);
    corner(OP_SUBTRACT_WITH_BORROW_OP, 8'h00, 8'h01, 8'h00);
    corner(OP_MUL, 8'h10, 8'h10, 8'h01);
    for (int i = 0; i < 200; i++) begin
      d = 8'($urandom);
      @(posedge clk);
      reg_index <= d[6:4];
      acc <= 8'($urandom);
      a = ($urandom % 4 == 0) ? 8'h7f : 8'($urandom);
      b = ($urandom % 4 == 0) ? 8'h00 : 8'($urandom);
      hi = ($urandom % 2) ? 8'h00 : 8'($urandom);
      case ($urandom % 3)
        0: begin
          sfr(1, 0, 0, b[0] ? 8'hd0 : 8'h50, d, 0, 0);
          if (b[0]) w[7:1] = d[7:1];
        end
        1: begin
          sfr(0, 0, 1, 8'hd0, 0, d[2:0], d[3]);
          if (d[2:0] != 3'h0) w[d[2:0]] = d[3];
        end
        default: begin
          {w[7], w[6], w[2]} = flags(ops[i % 5], a, b, hi, w[7]);
          arith(ops[i % 5], a, b, hi);
        end
      endcase
      chk("flags", {w[7:1], 1'b0}, {carry_flag, half_carry_flag, user_flag_a, bank_select,
        overflow_flag, user_flag_b, 1'b0});
      chk("reg_addr", {3'h0, w[4:3], reg_index}, {3'h0, reg_addr});
      sfr(0, 1, 0, 8'hd0, 0, 0, 0);
      chk("word", {w[7:1], ^acc}, sfr_rdata);
    end
    complete_run();
  end
  initial begin
    #30000;
    n_fail++;
    complete_run();
  end
endmodule : program_status_flags_tb
